/* File: core/pxd_pkg.sv */
package pxd_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_SCAN_CTRL = 8'h0a;
  localparam logic [7:0] ADDR_THRESH = 8'h0b;
  localparam logic [7:0] ADDR_DEB_COMP = 8'h0c;
  localparam logic [7:0] ADDR_STUCK = 8'h0d;
  localparam logic [7:0] ADDR_AVG_POS = 8'h0e;
  localparam logic [7:0] ADDR_RAW_COEFF = 8'h0f;
  localparam logic [7:0] ADDR_AVG_NEG = 8'h10;
  // ==========================================================
  // field positions
  localparam int RANGE_SEL_BIT = 7;
  localparam int IRQ_SEL_BIT = 6;
  localparam int HYST_LSB = 4;
  localparam int SCAN_LSB = 0;
  localparam int CLOSE_DEB_LSB = 6;
  localparam int FAR_DEB_LSB = 4;
  localparam int COMP_PRD_LSB = 0;
  localparam int RAW_COEFF_LSB = 0;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_SCAN_CTRL = 8'h00;
  localparam logic [7:0] RST_THRESH = 8'h00;
  localparam logic [7:0] RST_DEB_COMP = 8'h00;
  localparam logic [7:0] RST_STUCK = 8'h00;
  localparam logic [7:0] RST_AVG_POS = 8'h00;
  localparam logic [7:0] RST_RAW_COEFF = 8'h00;
  localparam logic [7:0] RST_AVG_NEG = 8'h00;
  // ==========================================================
  // scaling and counts
  localparam logic [15:0] HYST_CODE1 = 16'h0020;
  localparam logic [15:0] HYST_CODE2 = 16'h0080;
  localparam logic [15:0] HYST_CODE3 = 16'h0200;
  localparam logic [2:0] SLOW_SHIFT_BASE = 3'h4;
  localparam int SCAN_CNT_W = 15;
  // ==========================================================
  // types
  typedef struct packed {
    logic raw_filter_range_sel;
    logic irq_bit5_function_sel;
    logic [1:0] detect_hysteresis;
    logic [3:0] scan_interval_code;
    logic [7:0] detect_threshold;
    logic [1:0] close_debounce;
    logic [1:0] far_debounce;
    logic [3:0] periodic_comp_interval;
    logic [7:0] stuck_close_timeout;
    logic [7:0] avg_positive_threshold;
    logic [1:0] raw_filter_coeff;
    logic [7:0] avg_negative_threshold;
  } pxd_cfg_type;

  typedef enum logic [1:0] {
    PXD_FAR = 2'b01,
    PXD_CLOSE = 2'b10
  } pxd_state_type;
endpackage : pxd_pkg

/* File: core/pxd_core.sv */
`timescale 1ns/1ps
module pxd_core (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  output logic [7:0] reg_rdata,
  input wire logic touch_tick,
  input wire logic prox_valid,
  input wire logic [15:0] prox_value,
  output logic scan_start,
  output logic near_far_status,
  output logic far_detected_event,
  output logic conversion_done_event,
  output logic irq_bit5_event,
  output logic comp_request,
  output logic raw_filter_off,
  output logic [2:0] raw_filter_shift,
  output logic [15:0] detect_threshold_counts,
  output logic [15:0] hysteresis_counts,
  output logic [10:0] avg_pos_threshold_counts,
  output logic [11:0] avg_neg_threshold_counts
);

  // ==========================================================
  // helpers
  function automatic logic [3:0] deb_need(input logic [1:0] code);
    deb_need = 4'h1 << code;
  endfunction : deb_need

  function automatic logic [15:0] hyst_of(input logic [1:0] code);
    unique case (code)
      2'h0: hyst_of = 16'h0000;
      2'h1: hyst_of = pxd_pkg::HYST_CODE1;
      2'h2: hyst_of = pxd_pkg::HYST_CODE2;
      2'h3: hyst_of = pxd_pkg::HYST_CODE3;
    endcase
  endfunction : hyst_of

  // ==========================================================
  // register file
  pxd_pkg::pxd_cfg_type cfg_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= {pxd_pkg::RST_SCAN_CTRL, pxd_pkg::RST_THRESH, pxd_pkg::RST_DEB_COMP,
        pxd_pkg::RST_STUCK, pxd_pkg::RST_AVG_POS, pxd_pkg::RST_RAW_COEFF[1:0],
        pxd_pkg::RST_AVG_NEG};
    end else if (reg_wr) begin
      unique case (reg_addr)
        pxd_pkg::ADDR_SCAN_CTRL: begin
          cfg_reg.raw_filter_range_sel <= reg_wdata[pxd_pkg::RANGE_SEL_BIT];
          cfg_reg.irq_bit5_function_sel <= reg_wdata[pxd_pkg::IRQ_SEL_BIT];
          cfg_reg.detect_hysteresis <= reg_wdata[pxd_pkg::HYST_LSB +: 2];
          cfg_reg.scan_interval_code <= reg_wdata[pxd_pkg::SCAN_LSB +: 4];
        end
        pxd_pkg::ADDR_THRESH: cfg_reg.detect_threshold <= reg_wdata;
        pxd_pkg::ADDR_DEB_COMP: begin
          cfg_reg.close_debounce <= reg_wdata[pxd_pkg::CLOSE_DEB_LSB +: 2];
          cfg_reg.far_debounce <= reg_wdata[pxd_pkg::FAR_DEB_LSB +: 2];
          cfg_reg.periodic_comp_interval <= reg_wdata[pxd_pkg::COMP_PRD_LSB +: 4];
        end
        pxd_pkg::ADDR_STUCK: cfg_reg.stuck_close_timeout <= reg_wdata;
        pxd_pkg::ADDR_AVG_POS: cfg_reg.avg_positive_threshold <= reg_wdata;
        pxd_pkg::ADDR_RAW_COEFF: cfg_reg.raw_filter_coeff <= reg_wdata[pxd_pkg::RAW_COEFF_LSB +: 2];
        pxd_pkg::ADDR_AVG_NEG: cfg_reg.avg_negative_threshold <= reg_wdata;
        default: ;
      endcase
    end
  end

  // read data one cycle after the address; unmapped reads zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      unique case (reg_addr)
        pxd_pkg::ADDR_SCAN_CTRL: reg_rdata <= {cfg_reg.raw_filter_range_sel,
          cfg_reg.irq_bit5_function_sel, cfg_reg.detect_hysteresis,
          cfg_reg.scan_interval_code};
        pxd_pkg::ADDR_THRESH: reg_rdata <= cfg_reg.detect_threshold;
        pxd_pkg::ADDR_DEB_COMP: reg_rdata <= {cfg_reg.close_debounce,
          cfg_reg.far_debounce, cfg_reg.periodic_comp_interval};
        pxd_pkg::ADDR_STUCK: reg_rdata <= cfg_reg.stuck_close_timeout;
        pxd_pkg::ADDR_AVG_POS: reg_rdata <= cfg_reg.avg_positive_threshold;
        pxd_pkg::ADDR_RAW_COEFF: reg_rdata <= {6'h00, cfg_reg.raw_filter_coeff};
        pxd_pkg::ADDR_AVG_NEG: reg_rdata <= cfg_reg.avg_negative_threshold;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // derived settings, registered so outputs come from flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      raw_filter_off <= 1'b1;
      raw_filter_shift <= 3'h0;
      detect_threshold_counts <= 16'h0000;
      hysteresis_counts <= 16'h0000;
      avg_pos_threshold_counts <= 11'h000;
      avg_neg_threshold_counts <= 12'h000;
    end else begin
      if (cfg_reg.raw_filter_range_sel) begin
        raw_filter_off <= 1'b0;
        raw_filter_shift <= pxd_pkg::SLOW_SHIFT_BASE + {1'b0, cfg_reg.raw_filter_coeff};
      end else begin
        raw_filter_off <= (cfg_reg.raw_filter_coeff == 2'h0);
        raw_filter_shift <= {1'b0, cfg_reg.raw_filter_coeff};
      end
      detect_threshold_counts <= {4'h0, cfg_reg.detect_threshold, 4'h0};
      hysteresis_counts <= hyst_of(cfg_reg.detect_hysteresis);
      avg_pos_threshold_counts <= {cfg_reg.avg_positive_threshold, 3'h0};
      avg_neg_threshold_counts <= 12'h000 - {1'b0, cfg_reg.avg_negative_threshold, 3'h0};
    end
  end

  // ==========================================================
  // scan timing
  logic [pxd_pkg::SCAN_CNT_W-1:0] scan_cnt_reg;
  logic [pxd_pkg::SCAN_CNT_W-1:0] scan_period_m1;
  logic scan_on;

  assign scan_on = (cfg_reg.scan_interval_code != 4'h0);
  assign scan_period_m1 = (15'h0001 << (cfg_reg.scan_interval_code - 4'h1)) - 15'h0001;

  // >= so that shrinking the period mid-count cannot overrun
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scan_cnt_reg <= '0;
      scan_start <= 1'b0;
    end else if (!scan_on) begin
      scan_cnt_reg <= '0;
      scan_start <= 1'b0;
    end else if (touch_tick) begin
      if (scan_cnt_reg >= scan_period_m1) begin
        scan_cnt_reg <= '0;
        scan_start <= 1'b1;
      end else begin
        scan_cnt_reg <= scan_cnt_reg + 15'h0001;
        scan_start <= 1'b0;
      end
    end else begin
      scan_start <= 1'b0;
    end
  end

  // ==========================================================
  // proximity decision
  pxd_pkg::pxd_state_type state_reg;
  logic [3:0] deb_cnt_reg;
  logic samp;
  logic close_cond;
  logic far_cond;
  logic [16:0] value_ext;
  logic [16:0] far_limit;
  logic [3:0] close_need;
  logic [3:0] far_need;
  logic far_evt_next;

  assign samp = prox_valid && scan_on;
  assign value_ext = {prox_value[15], prox_value};
  assign far_limit = {1'b0, detect_threshold_counts} - {1'b0, hysteresis_counts};
  assign close_cond = $signed(value_ext) > $signed({1'b0, detect_threshold_counts});
  assign far_cond = $signed(value_ext) < $signed(far_limit);
  assign close_need = deb_need(cfg_reg.close_debounce);
  assign far_need = deb_need(cfg_reg.far_debounce);
  assign far_evt_next = samp && (state_reg == pxd_pkg::PXD_CLOSE) && far_cond &&
    (deb_cnt_reg + 4'h1 >= far_need);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= pxd_pkg::PXD_FAR;
      deb_cnt_reg <= 4'h0;
    end else if (samp) begin
      unique case (state_reg)
        pxd_pkg::PXD_FAR: begin
          if (!close_cond) begin
            deb_cnt_reg <= 4'h0;
          end else if (deb_cnt_reg + 4'h1 >= close_need) begin
            state_reg <= pxd_pkg::PXD_CLOSE;
            deb_cnt_reg <= 4'h0;
          end else begin
            deb_cnt_reg <= deb_cnt_reg + 4'h1;
          end
        end
        pxd_pkg::PXD_CLOSE: begin
          if (!far_cond) begin
            deb_cnt_reg <= 4'h0;
          end else if (far_evt_next) begin
            state_reg <= pxd_pkg::PXD_FAR;
            deb_cnt_reg <= 4'h0;
          end else begin
            deb_cnt_reg <= deb_cnt_reg + 4'h1;
          end
        end
        default: begin
          state_reg <= pxd_pkg::PXD_FAR;
          deb_cnt_reg <= 4'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      near_far_status <= 1'b0;
      far_detected_event <= 1'b0;
      conversion_done_event <= 1'b0;
      irq_bit5_event <= 1'b0;
    end else begin
      near_far_status <= samp ? ((state_reg == pxd_pkg::PXD_FAR) ?
        (close_cond && (deb_cnt_reg + 4'h1 >= close_need)) : !far_evt_next) :
        (state_reg == pxd_pkg::PXD_CLOSE);
      far_detected_event <= far_evt_next;
      conversion_done_event <= samp;
      irq_bit5_event <= cfg_reg.irq_bit5_function_sel ? samp : far_evt_next;
    end
  end

  // ==========================================================
  // compensation
  logic [10:0] comp_cnt_reg;
  logic [11:0] stuck_cnt_reg;
  logic [10:0] comp_limit_m1;
  logic [11:0] stuck_limit;
  logic comp_fire;
  logic stuck_fire;

  assign comp_limit_m1 = {cfg_reg.periodic_comp_interval, 7'h00} - 11'h001;
  assign stuck_limit = {cfg_reg.stuck_close_timeout, 4'h0};
  assign comp_fire = samp && (cfg_reg.periodic_comp_interval != 4'h0) &&
    (comp_cnt_reg >= comp_limit_m1);
  assign stuck_fire = samp && (state_reg == pxd_pkg::PXD_CLOSE) &&
    (cfg_reg.stuck_close_timeout != 8'h00) && (stuck_cnt_reg + 12'h001 >= stuck_limit);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      comp_cnt_reg <= 11'h000;
    end else if (cfg_reg.periodic_comp_interval == 4'h0) begin
      comp_cnt_reg <= 11'h000;
    end else if (comp_fire) begin
      comp_cnt_reg <= 11'h000;
    end else if (samp) begin
      comp_cnt_reg <= comp_cnt_reg + 11'h001;
    end
  end

  // counting only in close means leaving close restarts the timeout
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stuck_cnt_reg <= 12'h000;
    end else if (state_reg != pxd_pkg::PXD_CLOSE || cfg_reg.stuck_close_timeout == 8'h00) begin
      stuck_cnt_reg <= 12'h000;
    end else if (stuck_fire) begin
      stuck_cnt_reg <= 12'h000;
    end else if (samp) begin
      stuck_cnt_reg <= stuck_cnt_reg + 12'h001;
    end
  end

  // one pulse requests compensation for either the periodic or the stuck-close timeout
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      comp_request <= 1'b0;
    end else begin
      comp_request <= comp_fire || stuck_fire;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence close_entry_s;
    samp && state_reg == pxd_pkg::PXD_FAR && close_cond && deb_cnt_reg + 4'h1 >= close_need;
  endsequence

  sequence far_entry_s;
    samp && state_reg == pxd_pkg::PXD_CLOSE && far_cond && deb_cnt_reg + 4'h1 >= far_need;
  endsequence

  scan_off_idle_a: assert property (!scan_on [*2] |-> !scan_start)
    else $error("scan started while disabled");
  scan_tick_cause_a: assert property (scan_start |-> $past(touch_tick) && scan_cnt_reg == '0)
    else $error("scan start without tick");
  close_entry_a: assert property (close_entry_s |=> near_far_status && state_reg == pxd_pkg::PXD_CLOSE)
    else $error("close not entered");
  far_entry_a: assert property (far_entry_s |=> !near_far_status && far_detected_event)
    else $error("far not entered");
  hyst_hold_a: assert property (samp && state_reg == pxd_pkg::PXD_CLOSE && !far_cond |=> near_far_status)
    else $error("left close inside hysteresis");
  irq_select_a: assert property (irq_bit5_event |-> ($past(cfg_reg.irq_bit5_function_sel) ? conversion_done_event : far_detected_event))
    else $error("bit5 event mismatch");
  threshold_scale_a: assert property (##1 detect_threshold_counts == {4'h0, $past(cfg_reg.detect_threshold), 4'h0})
    else $error("threshold scale wrong");
  avg_scale_a: assert property (##1 (avg_pos_threshold_counts == {$past(cfg_reg.avg_positive_threshold), 3'h0}) && (avg_neg_threshold_counts + {1'b0, $past(cfg_reg.avg_negative_threshold), 3'h0} == 12'h000))
    else $error("average threshold scale wrong");
  slow_range_a: assert property (cfg_reg.raw_filter_range_sel |=> !raw_filter_off && raw_filter_shift >= 3'h4)
    else $error("slow range coefficient wrong");
  comp_off_a: assert property (cfg_reg.periodic_comp_interval == 4'h0 && cfg_reg.stuck_close_timeout == 8'h00 |=> !comp_request)
    else $error("compensation while disabled");
  stuck_bound_a: assert property (cfg_reg.stuck_close_timeout != 8'h00 |-> stuck_cnt_reg < stuck_limit)
    else $error("stuck count beyond limit");
  stuck_restart_a: assert property (state_reg == pxd_pkg::PXD_FAR |=> stuck_cnt_reg == 12'h000)
    else $error("stuck count kept after close");

endmodule : pxd_core

/* File: verif/pxd_fe_model.sv */
`timescale 1ns/1ps
// ==========================================================
// analog front end stand-in: touch ticks and scan samples
module pxd_fe_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scan_start,
  input wire logic [15:0] fe_value,
  output logic touch_tick,
  output logic prox_valid,
  output logic [15:0] prox_value
);
  logic [1:0] div_reg;
  logic [1:0] pend_reg;
  logic [15:0] held_reg;

  // tick every four clocks keeps one scan finished before the next
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 2'h0;
      touch_tick <= 1'b0;
    end else begin
      div_reg <= div_reg + 2'h1;
      touch_tick <= (div_reg == 2'h3);
    end
  end

  // value outside its valid cycle toggles so a stale read cannot pass
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_reg <= 2'h0;
      held_reg <= 16'h0000;
      prox_valid <= 1'b0;
      prox_value <= 16'h0000;
    end else begin
      pend_reg <= {pend_reg[0], scan_start};
      if (scan_start) held_reg <= fe_value;
      prox_valid <= pend_reg[1];
      prox_value <= pend_reg[1] ? held_reg : ~prox_value;
    end
  end
endmodule : pxd_fe_model

/* File: verif/pxd_core_tb.sv */
`timescale 1ns/1ps
module pxd_core_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_rdata;
  logic touch_tick, prox_valid, scan_start, near_far_status, far_detected_event;
  logic conversion_done_event, irq_bit5_event, comp_request, raw_filter_off;
  logic [15:0] prox_value, fe_value = 16'h0000, detect_threshold_counts, hysteresis_counts;
  logic [2:0] raw_filter_shift;
  logic [10:0] avg_pos_threshold_counts;
  logic [11:0] avg_neg_threshold_counts;
  logic rd_pend = 1'b0;
  logic [7:0] exp_rd[$];
  logic [3:0] exp_smp[$];
  logic [7:0] v[7];
  int miscompares = 0, n_tests = 0, scan_cnt = 0, tick_cnt = 0;

  always #4 clk = ~clk;

  pxd_core u_pxd_core (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rdata(reg_rdata), .touch_tick(touch_tick), .prox_valid(prox_valid),
    .prox_value(prox_value), .scan_start(scan_start), .near_far_status(near_far_status),
    .far_detected_event(far_detected_event), .conversion_done_event(conversion_done_event),
    .irq_bit5_event(irq_bit5_event), .comp_request(comp_request),
    .raw_filter_off(raw_filter_off), .raw_filter_shift(raw_filter_shift),
    .detect_threshold_counts(detect_threshold_counts), .hysteresis_counts(hysteresis_counts),
    .avg_pos_threshold_counts(avg_pos_threshold_counts),
    .avg_neg_threshold_counts(avg_neg_threshold_counts));

  pxd_fe_model u_pxd_fe_model (.clk(clk), .rst_n(rst_n), .scan_start(scan_start),
    .fe_value(fe_value), .touch_tick(touch_tick), .prox_valid(prox_valid),
    .prox_value(prox_value));

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  task automatic rst;
    @(negedge clk);
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
  endtask : rst

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    reg_addr = a;
    exp_rd.push_back(e);
    rd_pend = 1'b1;
    @(negedge clk);
    rd_pend = 1'b0;
  endtask : rd

  // hand the front end a value for the scan just started and note the outcome
  task automatic smp(input logic [15:0] val, input logic [3:0] e);
    int i;
    i = 0;
    @(posedge clk);
    #2;
    while (scan_start !== 1'b1 && i < 50) begin
      @(posedge clk);
      #2;
      i++;
    end
    chk(16'(i >= 50), 16'h0000);
    @(negedge clk);
    fe_value = val;
    exp_smp.push_back(e);
  endtask : smp

  task automatic drain;
    int i;
    for (i = 0; i < 40 && exp_smp.size() > 0; i++) @(negedge clk);
    chk(16'(exp_smp.size()), 16'h0000);
  endtask : drain

  // ==========================================================
  // monitor: oldest note is compared as each result appears
  always @(posedge clk) begin
    if (touch_tick === 1'b1) tick_cnt++;
    #2;
    if (scan_start === 1'b1) scan_cnt++;
    if (rd_pend) chk({8'h00, reg_rdata}, {8'h00, exp_rd.pop_front()});
    if (conversion_done_event === 1'b1 && exp_smp.size() > 0)
      chk({12'h000, near_far_status, far_detected_event, irq_bit5_event, comp_request},
          {12'h000, exp_smp.pop_front()});
  end

  initial begin
    #100000;
    miscompares++;
    complete_run();
  end

  // ==========================================================
  // main sequence
  initial begin
    logic [15:0] hy[4];
    logic [15:0] tv[10];
    logic [3:0] te[10];
    int i;
    int k;
    hy = '{16'h0000, 16'h0020, 16'h0080, 16'h0200};
    void'($urandom(32'h0e43));
    rst();
    for (i = 0; i < 7; i++) rd(8'h0a + 8'(i), 8'h00);
    rd(8'h20, 8'h00);
    chk({15'h0000, raw_filter_off}, 16'h0001);
    for (i = 0; i < 7; i++) begin
      v[i] = 8'($urandom());
      wr(8'h0a + 8'(i), v[i]);
      rd(8'h0a + 8'(i), (i == 5) ? (v[i] & 8'h03) : v[i]);
    end
    chk(detect_threshold_counts, {4'h0, v[1], 4'h0});
    chk({5'h00, avg_pos_threshold_counts}, {5'h00, v[4], 3'h0});
    chk({4'h0, avg_neg_threshold_counts}, {4'h0, 12'h000 - {1'b0, v[6], 3'h0}});
    for (k = 0; k < 8; k++) begin
      wr(8'h0a, {k[2], 1'b0, k[1:0], 4'h0});
      wr(8'h0f, {6'h00, k[1:0]});
      @(negedge clk);
      chk(hysteresis_counts, hy[k[1:0]]);
      chk({15'h0000, raw_filter_off}, {15'h0000, k == 0});
      if (k != 0) chk({13'h0000, raw_filter_shift}, {13'h0000, k[2], k[1:0]});
    end
    $display("registers test done");
    for (k = 0; k < 4; k++) begin
      rst();
      wr(8'h0a, 8'(k));
      scan_cnt = 0;
      tick_cnt = 0;
      for (i = 0; i < 100 && tick_cnt < 16; i++) @(negedge clk);
      repeat (2) @(negedge clk);
      chk(16'(scan_cnt), (k == 0) ? 16'h0000 : (16'h0010 >> (k - 1)));
    end
    $display("scan test done");
    rst();
    wr(8'h0b, 8'h02);
    wr(8'h0c, 8'h40);
    wr(8'h0a, 8'h11);
    tv = '{16'd33, 16'd10, 16'd40, 16'd32, 16'd40, 16'd40, 16'd0, 16'hffff, 16'd100, 16'd100};
    te = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h8, 4'h8, 4'h6, 4'h2, 4'ha};
    for (i = 0; i < 8; i++) smp(tv[i], te[i]);
    drain();
    wr(8'h0a, 8'h51);
    for (i = 8; i < 10; i++) smp(tv[i], te[i]);
    smp(16'hfffb, 4'h6);
    drain();
    $display("detection test done");
    rst();
    wr(8'h0c, 8'h10);
    wr(8'h0d, 8'h01);
    wr(8'h0a, 8'h01);
    smp(16'd100, 4'h8);
    for (i = 0; i < 16; i++) smp(16'd100, {3'b100, i == 15});
    smp(16'hffff, 4'h8);
    smp(16'd100, 4'h8);
    smp(16'hffff, 4'h8);
    smp(16'hffff, 4'h6);
    drain();
    $display("stuck test done");
    rst();
    wr(8'h0c, 8'hc1);
    wr(8'h0a, 8'h01);
    for (i = 0; i < 128; i++) begin
      smp((i < 120) ? 16'd0 : 16'd100, {i == 127, 2'b00, i == 127});
    end
    drain();
    $display("periodic test done");
    complete_run();
  end
endmodule : pxd_core_tb
